// File: logic/lsp_cfg.svh
/*
 * Constants for the link symbol path: control codes, marker numbers,
 * scrambler seed and clock-compensation windows.
 * Assumes it is included by bare name from the package and design file.
 */
`ifndef LSP_CFG_SVH
`define LSP_CFG_SVH

`define LSP_LANES          4
`define LSP_IDLE_SYM       8'h00
`define LSP_K_COM          8'hBC
`define LSP_K_EDB          8'h7C
`define LSP_K_SDP          8'hDC
`define LSP_K_EPF          8'hF7
`define LSP_K_SHP          8'hFB
`define LSP_K_END          8'hFD
`define LSP_K_SKP          8'h3C
`define LSP_MK_COM         3'h0
`define LSP_MK_EDB         3'h1
`define LSP_MK_SDP         3'h2
`define LSP_MK_EPF         3'h3
`define LSP_MK_SHP         3'h4
`define LSP_MK_END         3'h5
`define LSP_MK_SKP         3'h7
`define LSP_LFSR_SEED      16'hFFFF
`define LSP_SKP_WIN_X1     11'h588
`define LSP_SKP_WIN_X2     11'h2C4
`define LSP_SKP_WIN_X4     11'h162
`define LSP_SKP_SETS_X1    3'h4
`define LSP_SKP_SETS_X2    3'h2
`define LSP_SKP_SETS_X4    3'h1
`define LSP_RX_GAP_X1      11'h588
`define LSP_RX_GAP_X2      11'h2C4
`define LSP_RX_GAP_X4      11'h162

`endif

// File: logic/lsp_pkg.sv
/*
 * Types for the link symbol path.
 * Assumes lsp_cfg.svh sits in the include path.
 */
`include "lsp_cfg.svh"

package lsp_pkg;
    typedef enum logic [1:0] {
        LSP_WIDTH_X1 = 2'h0,
        LSP_WIDTH_X2 = 2'h1,
        LSP_WIDTH_X4 = 2'h2
    } lsp_width_t;

    typedef enum logic [1:0] {
        LSP_TX_IDLE = 2'h0,
        LSP_TX_PKT  = 2'h1,
        LSP_TX_SKP1 = 2'h3,
        LSP_TX_SKP2 = 2'h2
    } lsp_tx_state_t;
endpackage : lsp_pkg

// File: logic/lsp_symbol_path.sv
/*
 * Four-lane link symbol path, transmit and receive:
 * idle fill, SKP scheduling, markers, scrambling, SKP removal.
 * Assumes a symbol clock, 8b10b in the PHY, and
 * lane words with a K flag per lane from above.
 */
`timescale 1ns/1ps
`include "lsp_cfg.svh"

module lsp_symbol_path (
    input  wire logic                clk_in,
    input  wire logic                rst_b_in,
    input  wire logic                ce_in,
    input  wire logic [1:0]          link_width_in,
    input  wire logic                hs_burst_in,
    input  wire logic                scramble_off_in,
    input  wire logic                tx_pkt_valid_in,
    input  wire logic                tx_pkt_last_in,
    input  wire logic [31:0]         tx_pkt_data_in,
    input  wire logic [3:0]          tx_pkt_k_in,
    input  wire logic [3:0]          tx_pkt_lanes_in,
    output logic                     tx_pkt_ready_out,
    output logic                     tx_protocol_data_ready_out,
    output logic [31:0]              tx_sym_out,
    output logic [3:0]               tx_marker_valid_out,
    output logic [11:0]              tx_marker_out,
    input  wire logic                tx_phy_input_ready_in,
    input  wire logic [31:0]         rx_sym_in,
    input  wire logic [3:0]          rx_marker_valid_in,
    input  wire logic [11:0]         rx_marker_in,
    input  wire logic [3:0]          rx_lane_valid_in,
    input  wire logic [3:0]          rx_decode_err_in,
    output logic [31:0]              rx_data_out,
    output logic [3:0]               rx_k_out,
    output logic [3:0]               rx_valid_out,
    output logic [3:0]               rx_decode_err_out,
    output logic [3:0]               rx_skp_starve_out
);
    lsp_pkg::lsp_tx_state_t tx_state_q;
    lsp_pkg::lsp_tx_state_t tx_state_d;
    logic [10:0] z_q;
    logic [10:0] z_d;
    logic [2:0]  skp_owed_q;
    logic [2:0]  skp_owed_d;
    logic        burst_q;
    logic [2:0]  lanes_n;
    logic [10:0] skp_win;
    logic [2:0]  skp_sets;
    logic [10:0] skp_period;
    logic        burst_entry;
    logic        scr_en;
    logic [3:0]  lane_on;
    logic [31:0] tx_pre_sym;
    logic [3:0]  tx_pre_k;

    // Lane count and per-width SKP window; period spreads sets evenly
    assign lanes_n  = (link_width_in == 2'h0) ? 3'h1 :
                      (link_width_in == 2'h1) ? 3'h2 : 3'h4;
    assign skp_win  = (link_width_in == 2'h0) ? `LSP_SKP_WIN_X1 :
                      (link_width_in == 2'h1) ? `LSP_SKP_WIN_X2 :
                                                `LSP_SKP_WIN_X4;
    assign skp_sets = (link_width_in == 2'h0) ? `LSP_SKP_SETS_X1 :
                      (link_width_in == 2'h1) ? `LSP_SKP_SETS_X2 :
                                                `LSP_SKP_SETS_X4;
    // Schedule at half the per-set spacing so a maximum packet still fits
    assign skp_period  = (skp_win / {8'h00, skp_sets}) >> 1;
    assign lane_on     = (link_width_in == 2'h0) ? 4'h1 :
                         (link_width_in == 2'h1) ? 4'h3 : 4'hF;
    assign burst_entry = hs_burst_in && !burst_q;
    assign scr_en      = hs_burst_in && !scramble_off_in;

    // Packet data flows in the packet state and in idle with no SKP owed; SKP waits for the boundary
    assign tx_pkt_ready_out =
        hs_burst_in && (tx_state_q == lsp_pkg::LSP_TX_PKT ||
                        (tx_state_q == lsp_pkg::LSP_TX_IDLE &&
                         skp_owed_q == 3'h0));
    assign tx_protocol_data_ready_out = hs_burst_in;

    // Transmit sequencing: idle, packet, then owed SKP pairs on the enabled lanes
    always_comb begin
        tx_state_d = tx_state_q;
        skp_owed_d = skp_owed_q;
        z_d        = z_q;
        if (burst_entry) begin
            z_d        = 11'h000;
            skp_owed_d = 3'h0;
            tx_state_d = lsp_pkg::LSP_TX_IDLE;
        end else if (!hs_burst_in) begin
            tx_state_d = lsp_pkg::LSP_TX_IDLE;
        end else begin
            case (tx_state_q)
                lsp_pkg::LSP_TX_IDLE: begin
                    if (skp_owed_q != 3'h0) begin
                        tx_state_d = lsp_pkg::LSP_TX_SKP1;
                    end else if (tx_pkt_valid_in && !tx_pkt_last_in) begin
                        tx_state_d = lsp_pkg::LSP_TX_PKT;
                    end
                end
                lsp_pkg::LSP_TX_PKT: begin
                    if (tx_pkt_valid_in && tx_pkt_last_in) begin
                        tx_state_d = lsp_pkg::LSP_TX_IDLE;
                    end
                end
                lsp_pkg::LSP_TX_SKP1: begin
                    tx_state_d = lsp_pkg::LSP_TX_SKP2;
                end
                lsp_pkg::LSP_TX_SKP2: begin
                    skp_owed_d = skp_owed_q - 3'h1;
                    z_d        = 11'h000;
                    tx_state_d = lsp_pkg::LSP_TX_IDLE;
                end
                default: begin
                    tx_state_d = lsp_pkg::LSP_TX_IDLE;
                end
            endcase
            // Z counts per-lane symbols; fraction kept by not dividing early
            if (tx_state_q != lsp_pkg::LSP_TX_SKP1 &&
                tx_state_q != lsp_pkg::LSP_TX_SKP2) begin
                if (z_q + 11'h001 >= skp_period) begin
                    z_d = 11'h000;
                    if (skp_owed_d != 3'h7) begin
                        skp_owed_d = skp_owed_d + 3'h1;
                    end
                end else begin
                    z_d = z_q + 11'h001;
                end
            end
        end
    end

    // Lane words before scrambling: idle fill, packet bytes or SKP
    always_comb begin
        tx_pre_sym = {4{`LSP_IDLE_SYM}};
        tx_pre_k   = 4'h0;
        if (tx_state_q == lsp_pkg::LSP_TX_SKP1 ||
            tx_state_q == lsp_pkg::LSP_TX_SKP2) begin
            tx_pre_sym = {4{`LSP_K_SKP}};
            tx_pre_k   = lane_on;
        end else if (tx_pkt_ready_out && tx_pkt_valid_in) begin
            for (int i = 0; i < 4; i++) begin
                // Lanes a short last word leaves empty keep idle
                if (tx_pkt_lanes_in[i]) begin
                    tx_pre_sym[8*i +: 8] = tx_pkt_data_in[8*i +: 8];
                    tx_pre_k[i]          = tx_pkt_k_in[i];
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_state_q <= lsp_pkg::LSP_TX_IDLE;
            z_q        <= 11'h000;
            skp_owed_q <= 3'h0;
            burst_q    <= 1'b0;
        end else if (ce_in && tx_phy_input_ready_in) begin
            tx_state_q <= tx_state_d;
            z_q        <= z_d;
            skp_owed_q <= skp_owed_d;
            burst_q    <= hs_burst_in;
        end
    end

    // One lane slice per lane; the receive slice also strips SKP sets
    genvar g;
    generate
        for (g = 0; g < `LSP_LANES; g++) begin : g_lane
            lsp_lane u_lane (
                .clk_in           (clk_in),
                .rst_b_in         (rst_b_in),
                .ce_in            (ce_in),
                .lane_en_in       (lane_on[g]),
                .scr_en_in        (scr_en),
                .lanes_n_in       (lanes_n),
                .tx_adv_in        (ce_in && tx_phy_input_ready_in && hs_burst_in),
                .tx_sym_in        (tx_pre_sym[8*g +: 8]),
                .tx_k_in          (tx_pre_k[g]),
                .tx_sym_out       (tx_sym_out[8*g +: 8]),
                .tx_mk_valid_out  (tx_marker_valid_out[g]),
                .tx_mk_out        (tx_marker_out[3*g +: 3]),
                .rx_valid_in      (rx_lane_valid_in[g]),
                .rx_sym_in        (rx_sym_in[8*g +: 8]),
                .rx_mk_valid_in   (rx_marker_valid_in[g]),
                .rx_mk_in         (rx_marker_in[3*g +: 3]),
                .rx_err_in        (rx_decode_err_in[g]),
                .rx_data_out      (rx_data_out[8*g +: 8]),
                .rx_k_out         (rx_k_out[g]),
                .rx_valid_out     (rx_valid_out[g]),
                .rx_err_out       (rx_decode_err_out[g]),
                .rx_starve_out    (rx_skp_starve_out[g])
            );
        end
    endgenerate
endmodule : lsp_symbol_path

// Single lane: marker mapping, scrambler, descrambler, SKP removal
module lsp_lane (
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        ce_in,
    input  wire logic        lane_en_in,
    input  wire logic        scr_en_in,
    input  wire logic [2:0]  lanes_n_in,
    input  wire logic        tx_adv_in,
    input  wire logic [7:0]  tx_sym_in,
    input  wire logic        tx_k_in,
    output logic [7:0]       tx_sym_out,
    output logic             tx_mk_valid_out,
    output logic [2:0]       tx_mk_out,
    input  wire logic        rx_valid_in,
    input  wire logic [7:0]  rx_sym_in,
    input  wire logic        rx_mk_valid_in,
    input  wire logic [2:0]  rx_mk_in,
    input  wire logic        rx_err_in,
    output logic [7:0]       rx_data_out,
    output logic             rx_k_out,
    output logic             rx_valid_out,
    output logic             rx_err_out,
    output logic             rx_starve_out
);
    logic [15:0] tx_lfsr_q;
    logic [15:0] rx_lfsr_q;
    logic [10:0] rx_gap_q;
    logic [10:0] rx_gap_lim;
    logic [7:0]  tx_key;
    logic [7:0]  rx_key;
    logic [15:0] tx_next;
    logic [15:0] rx_next;
    logic [2:0]  tx_mk;
    logic [7:0]  rx_kcode;
    logic        tx_is_skp;
    logic        rx_is_skp;
    logic        tx_is_com;
    logic        rx_is_com;

    // Eight serial shifts of X16+X5+X4+X3+1; key taken from the high bits
    function automatic logic [15:0] lsp_adv8(input logic [15:0] s);
        logic [15:0] v;
        v = s;
        for (int i = 0; i < 8; i++) begin
            v = {v[14:0], 1'b0} ^ (v[15] ? 16'h0039 : 16'h0000);
        end
        return v;
    endfunction : lsp_adv8

    function automatic logic [7:0] lsp_key(input logic [15:0] s);
        logic [7:0] k;
        k = 8'h00;
        for (int i = 0; i < 8; i++) begin
            k[i] = s[15 - i];
        end
        return k;
    endfunction : lsp_key

    assign tx_next   = lsp_adv8(tx_lfsr_q);
    assign rx_next   = lsp_adv8(rx_lfsr_q);
    assign tx_key    = scr_en_in ? lsp_key(tx_lfsr_q) : 8'h00;
    assign rx_key    = scr_en_in ? lsp_key(rx_lfsr_q) : 8'h00;
    assign tx_is_skp = tx_k_in && tx_sym_in == `LSP_K_SKP;
    assign tx_is_com = tx_k_in && tx_sym_in == `LSP_K_COM;
    assign rx_is_skp = rx_mk_valid_in && rx_mk_in == `LSP_MK_SKP;
    assign rx_is_com = rx_mk_valid_in && rx_mk_in == `LSP_MK_COM;
    assign rx_gap_lim = (lanes_n_in == 3'h1) ? `LSP_RX_GAP_X1 :
                        (lanes_n_in == 3'h2) ? `LSP_RX_GAP_X2 :
                                               `LSP_RX_GAP_X4;

    // K codes to PHY markers and back; SKP travels as the filler marker
    assign tx_mk = (tx_sym_in == `LSP_K_COM) ? `LSP_MK_COM :
                   (tx_sym_in == `LSP_K_EDB) ? `LSP_MK_EDB :
                   (tx_sym_in == `LSP_K_SDP) ? `LSP_MK_SDP :
                   (tx_sym_in == `LSP_K_EPF) ? `LSP_MK_EPF :
                   (tx_sym_in == `LSP_K_SHP) ? `LSP_MK_SHP :
                   (tx_sym_in == `LSP_K_END) ? `LSP_MK_END : `LSP_MK_SKP;
    assign rx_kcode = (rx_mk_in == `LSP_MK_COM) ? `LSP_K_COM :
                      (rx_mk_in == `LSP_MK_EDB) ? `LSP_K_EDB :
                      (rx_mk_in == `LSP_MK_SDP) ? `LSP_K_SDP :
                      (rx_mk_in == `LSP_MK_EPF) ? `LSP_K_EPF :
                      (rx_mk_in == `LSP_MK_SHP) ? `LSP_K_SHP : `LSP_K_END;

    // Transmit register and scrambler; data outputs come from flops
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_lfsr_q       <= `LSP_LFSR_SEED;
            tx_sym_out      <= 8'h00;
            tx_mk_valid_out <= 1'b0;
            tx_mk_out       <= 3'h0;
        end else if (tx_adv_in) begin
            tx_sym_out      <= tx_k_in ? tx_sym_in : tx_sym_in ^ tx_key;
            tx_mk_valid_out <= tx_k_in && lane_en_in;
            tx_mk_out       <= tx_mk;
            if (tx_is_com) begin
                tx_lfsr_q <= `LSP_LFSR_SEED;
            end else if (!tx_is_skp) begin
                tx_lfsr_q <= tx_next;
            end
        end
    end

    // Receive: descramble, drop SKP, flag errors and overlong SKP gaps
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rx_lfsr_q     <= `LSP_LFSR_SEED;
            rx_data_out   <= 8'h00;
            rx_k_out      <= 1'b0;
            rx_valid_out  <= 1'b0;
            rx_err_out    <= 1'b0;
            rx_gap_q      <= 11'h000;
            rx_starve_out <= 1'b0;
        end else if (ce_in) begin
            rx_valid_out <= rx_valid_in && lane_en_in && !rx_is_skp;
            rx_err_out   <= rx_valid_in && rx_err_in;
            rx_k_out     <= rx_mk_valid_in;
            rx_data_out  <= rx_mk_valid_in ? rx_kcode : rx_sym_in ^ rx_key;
            if (rx_valid_in) begin
                if (rx_is_com) begin
                    rx_lfsr_q <= `LSP_LFSR_SEED;
                end else if (!rx_is_skp) begin
                    rx_lfsr_q <= rx_next;
                end
                // Gap counter only reports; data keeps flowing past the limit
                if (rx_is_skp) begin
                    rx_gap_q      <= 11'h000;
                    rx_starve_out <= 1'b0;
                end else if (rx_gap_q != 11'h7FF) begin
                    rx_gap_q      <= rx_gap_q + 11'h001;
                    rx_starve_out <= rx_gap_q >= rx_gap_lim;
                end
            end
        end
    end
endmodule : lsp_lane

// File: sim/lsp_link_partner.sv
/*
 * Far side: looped-back lanes, one symbol of delay.
 * Assumes the bench gives lane mask and errors.
 */
`timescale 1ns/1ps

module lsp_link_partner (
    input  wire logic        clk_in,
    input  wire logic        hs_burst_in,
    input  wire logic [3:0]  lane_mask_in,
    input  wire logic [3:0]  err_inj_in,
    input  wire logic [31:0] tx_sym_in,
    input  wire logic [3:0]  tx_marker_valid_in,
    input  wire logic [11:0] tx_marker_in,
    output logic [31:0]      rx_sym_out,
    output logic [3:0]       rx_marker_valid_out,
    output logic [11:0]      rx_marker_out,
    output logic [3:0]       rx_lane_valid_out,
    output logic [3:0]       rx_decode_err_out
);
    // Idle lanes start from a pattern, not from zero
    initial begin
        rx_sym_out = 32'h5AC3_96E1;
        rx_marker_out = 12'hA5A;
        {rx_marker_valid_out, rx_lane_valid_out, rx_decode_err_out} = 12'h000;
    end

    // Loop back in a burst; lanes go dead outside
    always @(posedge clk_in) begin
        if (hs_burst_in) begin
            rx_sym_out <= tx_sym_in;
            rx_marker_out <= tx_marker_in;
            rx_marker_valid_out <= tx_marker_valid_in & lane_mask_in;
            rx_lane_valid_out <= lane_mask_in;
            rx_decode_err_out <= err_inj_in & lane_mask_in & ~tx_marker_valid_in;
        end else begin
            rx_sym_out <= ~rx_sym_out;
            rx_marker_out <= ~rx_marker_out;
            {rx_marker_valid_out, rx_lane_valid_out, rx_decode_err_out} <= 12'h000;
        end
    end
endmodule : lsp_link_partner

// File: sim/lsp_sp_properties.sv
/*
 * Port checks for the link symbol path.
 * Assumes one clock and an async low reset.
 */
`timescale 1ns/1ps
`include "lsp_cfg.svh"

module lsp_sp_properties (
    input wire logic        clk_in,
    input wire logic        rst_b_in,
    input wire logic        ce_in,
    input wire logic [1:0]  link_width_in,
    input wire logic        hs_burst_in,
    input wire logic        scramble_off_in,
    input wire logic        tx_pkt_valid_in,
    input wire logic [31:0] tx_pkt_data_in,
    input wire logic [3:0]  tx_pkt_k_in,
    input wire logic [3:0]  tx_pkt_lanes_in,
    input wire logic        tx_pkt_ready_out,
    input wire logic        tx_protocol_data_ready_out,
    input wire logic [31:0] tx_sym_out,
    input wire logic [3:0]  tx_marker_valid_out,
    input wire logic [11:0] tx_marker_out,
    input wire logic        tx_phy_input_ready_in,
    input wire logic [3:0]  rx_marker_valid_in,
    input wire logic [11:0] rx_marker_in,
    input wire logic [3:0]  rx_lane_valid_in,
    input wire logic [3:0]  rx_decode_err_in,
    input wire logic [3:0]  rx_valid_out,
    input wire logic [3:0]  rx_decode_err_out,
    input wire logic [3:0]  rx_skp_starve_out
);
    // A 354-symbol window less two SKP pairs
    localparam int GAP_MAX = 350;
    logic        tx_skp;
    logic        rx_skp;
    logic        take;
    logic [10:0] rx_lim;
    logic [10:0] tx_gap_q;
    logic [10:0] tx_gap_d;
    logic [10:0] rx_gap_q;
    logic [10:0] rx_gap_d;

    // Lane 0 SKP, word taken, receive limit
    assign tx_skp = tx_marker_valid_out[0] && tx_marker_out[2:0] == `LSP_MK_SKP;
    assign rx_skp = rx_lane_valid_in[0] && rx_marker_valid_in[0]
                    && rx_marker_in[2:0] == `LSP_MK_SKP;
    assign take = ce_in && tx_phy_input_ready_in && tx_pkt_valid_in && tx_pkt_ready_out;
    assign rx_lim = (link_width_in == 2'h0) ? `LSP_RX_GAP_X1
                  : (link_width_in == 2'h1) ? `LSP_RX_GAP_X2 : `LSP_RX_GAP_X4;
    // Saturating counts since the last SKP; stalls send nothing
    assign tx_gap_d = (!hs_burst_in || tx_skp) ? 11'h000
                    : (ce_in && tx_phy_input_ready_in && tx_gap_q != 11'h7FF)
                    ? tx_gap_q + 11'h001 : tx_gap_q;
    assign rx_gap_d = rx_skp ? 11'h000
                    : (ce_in && rx_lane_valid_in[0] && rx_gap_q != 11'h7FF)
                    ? rx_gap_q + 11'h001 : rx_gap_q;

    // Gap counters
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_gap_q <= 11'h000;
            rx_gap_q <= 11'h000;
        end else begin
            tx_gap_q <= tx_gap_d;
            rx_gap_q <= rx_gap_d;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    chk_dready_burst: assert property (
        tx_protocol_data_ready_out == hs_burst_in) else $error("ready off burst");
    chk_refuse_pwm: assert property (
        !hs_burst_in |-> !tx_pkt_ready_out) else $error("taken off burst");
    chk_skp_pair: assert property (
        $rose(tx_skp) |=> tx_skp ##1 !tx_skp) else $error("SKP set length");
    chk_skp_lanes: assert property (
        tx_skp && link_width_in == 2'h2 |-> tx_marker_valid_out == 4'hF
        && tx_marker_out == 12'hFFF) else $error("SKP lane missing");
    chk_skp_gap_max: assert property (
        tx_gap_q <= GAP_MAX) else $error("SKP gap long");
    chk_tx_word: assert property (
        take && scramble_off_in && tx_pkt_k_in == 4'h0 && tx_pkt_lanes_in == 4'hF
        |=> tx_sym_out == $past(tx_pkt_data_in) && tx_marker_valid_out == 4'h0)
        else $error("word not sent");
    chk_k_plain: assert property (
        take && tx_pkt_k_in[0] && tx_pkt_lanes_in[0] |=> tx_marker_valid_out[0]
        && tx_sym_out[7:0] == $past(tx_pkt_data_in[7:0])) else $error("K altered");
    chk_rx_skp_drop: assert property (
        rx_skp && ce_in |=> !rx_valid_out[0]) else $error("SKP passed");
    chk_rx_pass: assert property (
        ce_in && hs_burst_in && rx_lane_valid_in[0] && !rx_marker_valid_in[0]
        |=> rx_valid_out[0]) else $error("symbol lost");
    chk_rx_err: assert property (
        ce_in && hs_burst_in && rx_lane_valid_in[1] && rx_decode_err_in[1]
        && !rx_marker_valid_in[1] |=> rx_decode_err_out[1]) else $error("error dropped");
    chk_starve_tol: assert property (
        rx_gap_q <= rx_lim |-> !rx_skp_starve_out[0]) else $error("early starve");
endmodule : lsp_sp_properties

bind lsp_symbol_path lsp_sp_properties i_chk (.*);

// File: sim/tb.sv
/*
 * Bench for the link symbol path with a loopback partner.
 * Assumes the checker binds itself.
 */
`timescale 1ns/1ps
`include "lsp_cfg.svh"

module tb;
    logic        clk_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic        ce_in = 1'b1;
    logic [1:0]  link_width_in = 2'h2;
    logic        hs_burst_in = 1'b0;
    logic        scramble_off_in = 1'b0;
    logic        tx_pkt_valid_in = 1'b0;
    logic        tx_pkt_last_in = 1'b0;
    logic [31:0] tx_pkt_data_in = 32'h0;
    logic [3:0]  tx_pkt_k_in = 4'h0;
    logic [3:0]  tx_pkt_lanes_in = 4'hF;
    logic        tx_phy_input_ready_in = 1'b1;
    logic [3:0]  err_inj = 4'h0;
    logic [3:0]  lane_mask;
    logic        tx_pkt_ready_out;
    logic        tx_protocol_data_ready_out;
    logic [31:0] tx_sym_out;
    logic [3:0]  tx_marker_valid_out;
    logic [11:0] tx_marker_out;
    logic [31:0] rx_sym_in;
    logic [3:0]  rx_marker_valid_in;
    logic [11:0] rx_marker_in;
    logic [3:0]  rx_lane_valid_in;
    logic [3:0]  rx_decode_err_in;
    logic [31:0] rx_data_out;
    logic [3:0]  rx_k_out;
    logic [3:0]  rx_valid_out;
    logic [3:0]  rx_decode_err_out;
    logic [3:0]  rx_skp_starve_out;
    int          n_errors = 0;
    int          samples_checked = 0;

    // Symbol clock and the lanes in use at each width
    always #4 clk_in = ~clk_in;
    assign lane_mask = (link_width_in == 2'h0) ? 4'h1 : (link_width_in == 2'h1) ? 4'h3 : 4'hF;

    lsp_symbol_path i_lsp_symbol_path (.*);

    lsp_link_partner i_lsp_link_partner (
        .clk_in(clk_in), .hs_burst_in(hs_burst_in), .lane_mask_in(lane_mask),
        .err_inj_in(err_inj), .tx_sym_in(tx_sym_out), .tx_marker_valid_in(tx_marker_valid_out),
        .tx_marker_in(tx_marker_out), .rx_sym_out(rx_sym_in),
        .rx_marker_valid_out(rx_marker_valid_in), .rx_marker_out(rx_marker_in),
        .rx_lane_valid_out(rx_lane_valid_in), .rx_decode_err_out(rx_decode_err_in));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic ok, input string what);
        samples_checked++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask : check

    // Offer a word; bounded wait for the taking edge
    task automatic put(input logic [31:0] d, input logic [3:0] k, input logic [3:0] ln,
                       input logic lst, output int n);
        tx_pkt_valid_in <= 1'b1;
        tx_pkt_data_in <= d;
        tx_pkt_k_in <= k;
        tx_pkt_lanes_in <= ln;
        tx_pkt_last_in <= lst;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (!(tx_pkt_ready_out === 1'b1 && tx_phy_input_ready_in === 1'b1) && n < 999);
        if (n >= 999) begin
            check(1'b0, "word never taken");
            tally_and_finish();
        end
        if (lst) tx_pkt_valid_in <= 1'b0;
    endtask : put

    task automatic t_pwm();
        repeat (3) begin
            @(posedge clk_in);
            check(tx_pkt_ready_out === 1'b0 && tx_protocol_data_ready_out === 1'b0, "ready");
            check(tx_sym_out === 32'h0 && rx_valid_out === 4'h0, "reset outputs");
        end
        $display("test pwm done");
    endtask : t_pwm

    task automatic t_markers();
        logic [7:0] kb [6];
        logic [2:0] mk [6];
        int         n;
        kb = '{`LSP_K_COM, `LSP_K_EDB, `LSP_K_SDP, `LSP_K_EPF, `LSP_K_SHP, `LSP_K_END};
        mk = '{`LSP_MK_COM, `LSP_MK_EDB, `LSP_MK_SDP, `LSP_MK_EPF, `LSP_MK_SHP, `LSP_MK_END};
        for (int i = 0; i < 6; i++) begin
            put({4{kb[i]}}, 4'hF, 4'hF, 1'b1, n);
            @(posedge clk_in);
            check(tx_marker_valid_out === 4'hF && tx_marker_out === {4{mk[i]}}, "marker");
            check(tx_sym_out === {4{kb[i]}}, "K sent scrambled");
            repeat (2) @(posedge clk_in);
            check(rx_data_out === {4{kb[i]}} && rx_k_out === 4'hF, "K not received");
        end
        $display("test markers done");
    endtask : t_markers

    task automatic t_idle();
        logic nz;
        nz = 1'b0;
        repeat (60) begin
            @(posedge clk_in);
            if (tx_marker_valid_out === 4'h0 && tx_sym_out !== 32'h0) nz = 1'b1;
            if (rx_valid_out === 4'hF && rx_k_out === 4'h0)
                check(rx_data_out === 32'h0, "idle bad");
        end
        check(nz, "idle plain");
        scramble_off_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        repeat (20) begin
            @(posedge clk_in);
            if (tx_marker_valid_out === 4'h0) check(tx_sym_out === 32'h0, "plain idle");
        end
        $display("test idle done");
    endtask : t_idle

    task automatic t_packets();
        int n;
        put(32'h1122_3344, 4'h0, 4'hF, 1'b0, n);
        put(32'h5566_7788, 4'h0, 4'h3, 1'b1, n);
        check(n == 1, "packet broken");
        @(posedge clk_in);
        check(tx_sym_out === 32'h0000_7788, "pad");
        for (int i = 0; i < 150; i++) begin
            put(32'hA000_0000 + i, 4'h0, 4'hF, i == 149, n);
            if (i > 0) check(n == 1 && tx_sym_out === 32'hA000_0000 + i - 1, "gap in packet");
        end
        @(posedge clk_in);
        check(tx_sym_out === 32'hA000_0095, "last word");
        put(32'hC0DE_0001, 4'h0, 4'hF, 1'b0, n);
        tx_phy_input_ready_in <= 1'b0;
        repeat (3) begin
            @(posedge clk_in);
            check(tx_sym_out === 32'hC0DE_0001, "stall moved");
        end
        tx_phy_input_ready_in <= 1'b1;
        put(32'hC0DE_0002, 4'h0, 4'hF, 1'b1, n);
        @(posedge clk_in);
        check(tx_sym_out === 32'hC0DE_0002, "word after stall");
        $display("test packets done");
    endtask : t_packets

    task automatic t_rxerr();
        logic seen;
        seen = 1'b0;
        err_inj <= 4'h2;
        for (int i = 0; i < 7; i++) begin
            @(posedge clk_in);
            if (i == 2) err_inj <= 4'h0;
            if (rx_decode_err_out[1] === 1'b1) seen = 1'b1;
        end
        check(seen, "no decode error");
        $display("test rxerr done");
    endtask : t_rxerr

    task automatic t_skp();
        int         cnt [4];
        logic [3:0] prev;
        logic       s;
        for (int w = 0; w < 3; w++) begin
            hs_burst_in <= 1'b0;
            link_width_in <= w[1:0];
            repeat (4) @(posedge clk_in);
            hs_burst_in <= 1'b1;
            cnt = '{default: 0};
            prev = 4'h0;
            repeat (800) begin
                @(posedge clk_in);
                for (int l = 0; l < 4; l++) begin
                    s = tx_marker_valid_out[l] === 1'b1 && tx_marker_out[3*l +: 3] === 3'h7;
                    if (s && !prev[l]) cnt[l]++;
                    prev[l] = s;
                end
            end
            check(cnt[0] >= 2, "too few SKP sets");
            for (int l = 1; l < 4; l++)
                if (lane_mask[l]) check(cnt[l] == cnt[0], "SKP lanes differ");
        end
        $display("test skp done");
    endtask : t_skp

    // Main sequence
    initial begin
        repeat (6) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_pwm();
        hs_burst_in <= 1'b1;
        t_markers();
        t_idle();
        t_packets();
        t_rxerr();
        t_skp();
        tally_and_finish();
    end
endmodule : tb
